/* File: hdl/ncd_decode.sv */
// Control-flow, compare, bit and I/O instruction decoder and executor
// Function
// - Immediate differs from memory sets status
// - A or B differs from memory sets status
// - Y differs from immediate sets status
// - Immediate at most memory sets status
// - A at most memory sets status
// - B at most memory sets status
// - A at most immediate sets status
// - Set, clear or test memory bit
// - Branches on status, long jump unconditional
// - Short call on status, two cycles
// - Long call on status, two words
// - Returns take three cycles; interrupt return restores
// - Set, clear, test discrete pin latches
// - Move nibbles to and from port registers
// - Standby enters standby, watch from subactive
`include "ncd_map.svh"
module ncd_decode
	import ncd_pkg::*;
#(
	parameter int PC_W = 14,
	parameter int SP_DEPTH = 4
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_instr_valid,
	input wire logic [9:0] i_instr,
	input wire ncd_regs_s i_regs,
	input wire logic i_subactive,
	input wire logic i_stop_watch,
	output logic [PC_W-1:0] o_pc,
	output logic o_status,
	output logic o_irq_enable_flag,
	output logic o_carry_flag,
	output logic o_mem_we,
	output logic [3:0] o_mem_wdata,
	output logic o_mem_direct,
	output logic [9:0] o_mem_addr,
	output logic o_acc_we,
	output logic o_breg_we,
	output logic [3:0] o_reg_wdata,
	output logic [15:0] o_pin_latch,
	output logic [63:0] o_port_regs,
	output ncd_pmode_e o_pmode,
	output logic o_busy
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ncd_state_e state_r; // Sequencer state
	logic [9:0] first_r; // Held first word of a two-word form
	logic [1:0] wait_r; // Remaining wait cycles
	logic [PC_W-1:0] pc_r; // Program counter
	logic st_r; // Status flag
	logic ie_r; // Interrupt enable flag
	logic ca_r; // Carry flag
	logic [PC_W+1:0] stack_r [SP_DEPTH]; // Return stack: pc, carry, status
	logic [$clog2(SP_DEPTH)-1:0] sp_r; // Stack pointer
	logic [15:0] latch_r; // Discrete pin latches
	logic [3:0] port_r [16]; // Port registers
	logic mem_we_r; // Memory write strobe
	logic [3:0] mem_wdata_r; // Memory write data
	logic mem_direct_r; // Direct addressing used
	logic [9:0] mem_addr_r; // Direct address
	logic acc_we_r; // Accumulator write strobe
	logic breg_we_r; // B write strobe
	logic [3:0] reg_wdata_r; // Register write data
	ncd_pmode_e pmode_r; // Power mode request
	// ----------------------------------------------------------------
	// Operand selection and compare
	// ----------------------------------------------------------------
	logic [9:0] op; // Opcode word under execution
	logic [9:0] ext; // Second word (address or target)
	logic two_done; // Executing after second word
	logic ne_r_imm_mem, ne_acc, ne_breg, ne_y, le_imm, le_acc, le_breg, le_ai;
	logic [PC_W-1:0] pc_inc; // Next sequential address
	assign two_done = (state_r == NCD_SECOND);
	assign op = two_done ? first_r : i_instr;
	assign ext = i_instr;
	assign pc_inc = pc_r + {{(PC_W-1){1'b0}}, 1'b1};
	ncd_cmp u_cmp_im (.i_lhs(op[3:0]), .i_rhs(i_regs.mem), .o_nonzero_result(ne_r_imm_mem),
		.o_no_borrow_result(le_imm));
	ncd_cmp u_cmp_am (.i_lhs(i_regs.acc), .i_rhs(i_regs.mem), .o_nonzero_result(ne_acc),
		.o_no_borrow_result(le_acc));
	ncd_cmp u_cmp_bm (.i_lhs(i_regs.breg), .i_rhs(i_regs.mem), .o_nonzero_result(ne_breg),
		.o_no_borrow_result(le_breg));
	ncd_cmp u_cmp_yi (.i_lhs(i_regs.yidx), .i_rhs(op[3:0]), .o_nonzero_result(ne_y),
		.o_no_borrow_result());
	ncd_cmp u_cmp_ai (.i_lhs(i_regs.acc), .i_rhs(op[3:0]), .o_nonzero_result(),
		.o_no_borrow_result(le_ai));
	// Two-word opcode detection
	logic is_two;
	always_comb
	begin
		is_two = 1'b0;
		if (op[9:4] == `NCD_OP_IMM_NE_MEM_CMP_DIRECT || op[9:4] == `NCD_OP_IMM_LE_MEM_CMP_DIRECT)
			is_two = 1'b1;
		else if (op == `NCD_W_ACC_NE_MEM_CMP_DIRECT || op == `NCD_W_ACC_LE_MEM_CMP_DIRECT)
			is_two = 1'b1;
		else if (op[9:6] == `NCD_HI_BITD && op[5:4] != 2'b11)
			is_two = 1'b1;
		else if (op[9:4] == `NCD_OP_BRL || op[9:4] == `NCD_OP_LONG_UNCOND_JUMP
			|| op[9:4] == `NCD_OP_CALL)
			is_two = 1'b1;
	end
	logic go; // An instruction executes this cycle
	assign go = (state_r == NCD_RUN && i_instr_valid && !is_two)
		|| (two_done && i_instr_valid);
	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Holds two-word first words and times multi-cycle forms
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			state_r <= NCD_RUN;
			first_r <= 10'h000;
			wait_r <= 2'h0;
		end
		else
		begin
			case (state_r)
				NCD_RUN:
				if (i_instr_valid && is_two)
				begin
					state_r <= NCD_SECOND;
					first_r <= i_instr;
				end
				else if (i_instr_valid && (i_instr == `NCD_W_RTN || i_instr == `NCD_W_INTERRUPT_RETURN))
				begin
					state_r <= NCD_WAIT;
					wait_r <= 2'(`NCD_RET_CYC - 2);
					first_r <= i_instr; // Last wait cycle must know which return
				end
				else if (i_instr_valid && i_instr[9:6] == 4'h7)
				begin
					state_r <= NCD_WAIT;
					wait_r <= 2'h0;
					first_r <= i_instr; // Keeps a stale return word from acting
				end
				NCD_SECOND:
				if (i_instr_valid)
					state_r <= NCD_RUN;
				NCD_WAIT:
				if (wait_r == 2'h0)
					state_r <= NCD_RUN;
				else
					wait_r <= wait_r - 2'h1;
				default:
					state_r <= NCD_RUN;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Status, flags, program counter and stack
	// ----------------------------------------------------------------
	logic st_nxt;
	always_comb
	begin
		st_nxt = `NCD_ST_RST;
		if (op[9:4] == `NCD_OP_IMM_NE_MEM_CMP || op[9:4] == `NCD_OP_IMM_NE_MEM_CMP_DIRECT)
			st_nxt = ne_r_imm_mem;
		else if (op == `NCD_W_ACC_NE_MEM_CMP || op == `NCD_W_ACC_NE_MEM_CMP_DIRECT)
			st_nxt = ne_acc;
		else if (op == `NCD_W_BREG_NE_MEM_CMP)
			st_nxt = ne_breg;
		else if (op[9:4] == `NCD_OP_INDEX_NE_IMM_CMP)
			st_nxt = ne_y;
		else if (op[9:4] == `NCD_OP_IMM_LE_MEM_CMP || op[9:4] == `NCD_OP_IMM_LE_MEM_CMP_DIRECT)
			st_nxt = le_imm;
		else if (op == `NCD_W_ACC_LE_MEM_CMP || op == `NCD_W_ACC_LE_MEM_CMP_DIRECT)
			st_nxt = le_acc;
		else if (op == `NCD_W_BREG_LE_MEM_CMP)
			st_nxt = le_breg;
		else if (op[9:4] == `NCD_OP_ACC_LE_IMM_CMP)
			st_nxt = le_ai;
		else if ((op[9:6] == `NCD_HI_BIT || op[9:6] == `NCD_HI_BITD) && op[5:2] == 4'h3)
			st_nxt = i_regs.mem[op[1:0]];
		else if (op == `NCD_W_TD)
			st_nxt = latch_r[i_regs.yidx];
		else if (op[9:4] == `NCD_OP_TDD)
			st_nxt = latch_r[op[3:0]];
	end
	// Flow control: branches, calls, returns
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			pc_r <= `NCD_PC_RST;
			st_r <= `NCD_ST_RST;
			ie_r <= 1'b0;
			ca_r <= 1'b0;
			sp_r <= '0;
			for (int k = 0; k < SP_DEPTH; k++)
				stack_r[k] <= '0;
		end
		else if (state_r == NCD_WAIT)
		begin
			if (wait_r == 2'h0 && first_r == `NCD_W_INTERRUPT_RETURN)
			begin
				ie_r <= 1'b1;
				ca_r <= stack_r[sp_r + 1'b1][1];
				st_r <= stack_r[sp_r + 1'b1][0];
			end
		end
		else if (i_instr_valid)
		begin
			pc_r <= pc_inc;
			if (go)
			begin
				st_r <= st_nxt;
				if (op[9:8] == 2'b11 && st_r)
					pc_r <= {pc_r[PC_W-1:8], op[7:0]};
				else if ((op[9:4] == `NCD_OP_BRL && st_r) || op[9:4] == `NCD_OP_LONG_UNCOND_JUMP)
					pc_r <= PC_W'({op[3:0], ext});
				else if ((op[9:6] == 4'h7 || op[9:4] == `NCD_OP_CALL) && st_r)
				begin
					stack_r[sp_r + 1'b1] <= {pc_inc, ca_r, st_r};
					sp_r <= sp_r + 1'b1;
					pc_r <= (op[9:6] == 4'h7) ? PC_W'(op[5:0]) : PC_W'({op[3:0], ext});
				end
				else if (op == `NCD_W_RTN || op == `NCD_W_INTERRUPT_RETURN)
				begin
					pc_r <= stack_r[sp_r][PC_W+1:2];
					sp_r <= sp_r - 1'b1;
				end
			end
		end
	end
	// Return flags are read one slot above after pop
	// ----------------------------------------------------------------
	// Memory, register and port side effects
	// ----------------------------------------------------------------
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
		begin
			mem_we_r <= 1'b0;
			mem_wdata_r <= 4'h0;
			mem_direct_r <= 1'b0;
			mem_addr_r <= 10'h000;
			acc_we_r <= 1'b0;
			breg_we_r <= 1'b0;
			reg_wdata_r <= 4'h0;
			latch_r <= 16'h0000;
			pmode_r <= NCD_PM_ACTIVE;
			for (int k = 0; k < 16; k++)
				port_r[k] <= 4'h0;
		end
		else
		begin
			mem_we_r <= 1'b0;
			acc_we_r <= 1'b0;
			breg_we_r <= 1'b0;
			mem_direct_r <= two_done;
			mem_addr_r <= two_done ? ext : 10'h000;
			if (go && (op[9:6] == `NCD_HI_BIT || op[9:6] == `NCD_HI_BITD)
				&& (op[5:2] == 4'h1 || op[5:2] == 4'h2))
			begin
				mem_we_r <= 1'b1;
				mem_wdata_r <= i_regs.mem;
				mem_wdata_r[op[1:0]] <= ~op[3];
			end
			if (go && op == `NCD_W_SED)
				latch_r[i_regs.yidx] <= 1'b1;
			else if (go && op == `NCD_W_RED)
				latch_r[i_regs.yidx] <= 1'b0;
			else if (go && op[9:4] == `NCD_OP_PIN_LATCH_SET_DIRECT)
				latch_r[op[3:0]] <= 1'b1;
			else if (go && op[9:4] == `NCD_OP_PIN_LATCH_CLEAR_DIRECT)
				latch_r[op[3:0]] <= 1'b0;
			if (go && (op[9:4] == `NCD_OP_LAR || op[9:4] == `NCD_OP_LBR))
			begin
				acc_we_r <= (op[9:4] == `NCD_OP_LAR);
				breg_we_r <= (op[9:4] == `NCD_OP_LBR);
				reg_wdata_r <= port_r[op[3:0]];
			end
			else if (go && op[9:4] == `NCD_OP_LRA)
				port_r[op[3:0]] <= i_regs.acc;
			else if (go && op[9:4] == `NCD_OP_LRB)
				port_r[op[3:0]] <= i_regs.breg;
			if (go && op == `NCD_W_SBY)
				pmode_r <= i_subactive ? NCD_PM_WATCH : NCD_PM_STANDBY;
			else if (go && op == `NCD_W_STOP)
				pmode_r <= i_stop_watch ? NCD_PM_WATCH : NCD_PM_STOP;
		end
	end
	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic busy_r;
	always_ff @(posedge i_core_clk)
	begin
		if (!i_rst_n)
			busy_r <= 1'b0;
		else
			busy_r <= (state_r == NCD_WAIT && wait_r != 2'h0)
				|| (state_r == NCD_RUN && i_instr_valid
				&& (i_instr[9:6] == 4'h7 || i_instr == `NCD_W_RTN || i_instr == `NCD_W_INTERRUPT_RETURN));
	end
	assign o_pc = pc_r;
	assign o_status = st_r;
	assign o_irq_enable_flag = ie_r;
	assign o_carry_flag = ca_r;
	assign o_mem_we = mem_we_r;
	assign o_mem_wdata = mem_wdata_r;
	assign o_mem_direct = mem_direct_r;
	assign o_mem_addr = mem_addr_r;
	assign o_acc_we = acc_we_r;
	assign o_breg_we = breg_we_r;
	assign o_reg_wdata = reg_wdata_r;
	assign o_pin_latch = latch_r;
	assign o_pmode = pmode_r;
	assign o_busy = busy_r;
	for (genvar g = 0; g < 16; g++)
	begin : g_port
		assign o_port_regs[g*4 +: 4] = port_r[g];
	end
endmodule // ncd_decode

/* File: hdl/ncd_map.svh */
// Opcode fields, reset values and timing counts of the control-flow decoder
`ifndef NCD_MAP_SVH
`define NCD_MAP_SVH
`define NCD_IW 10
`define NCD_ST_RST 1'b1
`define NCD_RET_CYC 3
`define NCD_PC_RST 14'h0000
`define NCD_OP_IMM_NE_MEM_CMP 6'h02
`define NCD_OP_IMM_NE_MEM_CMP_DIRECT 6'h12
`define NCD_OP_IMM_LE_MEM_CMP 6'h03
`define NCD_OP_IMM_LE_MEM_CMP_DIRECT 6'h13
`define NCD_OP_INDEX_NE_IMM_CMP 6'h07
`define NCD_OP_ACC_LE_IMM_CMP 6'h2b
`define NCD_OP_PIN_LATCH_SET_DIRECT 6'h2e
`define NCD_OP_PIN_LATCH_CLEAR_DIRECT 6'h26
`define NCD_OP_TDD 6'h2a
`define NCD_OP_LAR 6'h25
`define NCD_OP_LBR 6'h24
`define NCD_OP_LRA 6'h2d
`define NCD_OP_LRB 6'h2c
`define NCD_OP_BRL 6'h17
`define NCD_OP_LONG_UNCOND_JUMP 6'h15
`define NCD_OP_CALL 6'h16
`define NCD_W_ACC_NE_MEM_CMP 10'h004
`define NCD_W_ACC_NE_MEM_CMP_DIRECT 10'h104
`define NCD_W_BREG_NE_MEM_CMP 10'h044
`define NCD_W_ACC_LE_MEM_CMP 10'h014
`define NCD_W_ACC_LE_MEM_CMP_DIRECT 10'h114
`define NCD_W_BREG_LE_MEM_CMP 10'h0c4
`define NCD_W_RTN 10'h010
`define NCD_W_INTERRUPT_RETURN 10'h011
`define NCD_W_SED 10'h0e4
`define NCD_W_RED 10'h064
`define NCD_W_TD 10'h0e0
`define NCD_W_SBY 10'h14c
`define NCD_W_STOP 10'h14d
`define NCD_HI_BIT 4'h2
`define NCD_HI_BITD 4'h6
`endif

/* File: hdl/ncd_pkg.sv */
// Types shared by the control-flow decoder files
package ncd_pkg;
	typedef enum logic [1:0] {NCD_RUN, NCD_SECOND, NCD_WAIT} ncd_state_e;
	typedef enum logic [1:0] {NCD_PM_ACTIVE, NCD_PM_STANDBY, NCD_PM_STOP, NCD_PM_WATCH}
		ncd_pmode_e;
	// Register view handed from the core
	typedef struct packed
	{
		logic [3:0] acc;
		logic [3:0] breg;
		logic [3:0] yidx;
		logic [3:0] mem;
	} ncd_regs_s;
endpackage

/* File: hdl/ncd_cmp.sv */
// Nibble comparison unit: inequality and no-borrow less-or-equal
module ncd_cmp
	import ncd_pkg::*;
(
	input wire logic [3:0] i_lhs,
	input wire logic [3:0] i_rhs,
	output logic o_nonzero_result,
	output logic o_no_borrow_result
);
	logic [4:0] diff;
	// rhs - lhs; no borrow means lhs <= rhs
	assign diff = {1'b0, i_rhs} - {1'b0, i_lhs};
	assign o_nonzero_result = (i_lhs != i_rhs);
	assign o_no_borrow_result = ~diff[4];
endmodule // ncd_cmp

/* File: tb/ncd_decode_sva.sv */
// Port checker for the control-flow decoder
`include "ncd_map.svh"
module ncd_decode_sva
	import ncd_pkg::*;
#(
	parameter int PC_W = 14,
	parameter int SP_DEPTH = 4
)
(
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_instr_valid,
	input wire logic [9:0] i_instr,
	input wire ncd_regs_s i_regs,
	input wire logic i_subactive,
	input wire logic [PC_W-1:0] o_pc,
	input wire logic o_status,
	input wire logic o_irq_enable_flag,
	input wire logic [15:0] o_pin_latch,
	input wire logic [63:0] o_port_regs,
	input wire ncd_pmode_e o_pmode,
	input wire logic o_busy
);
	// ------------------------------
	// Word tracking
	// ------------------------------
	logic sec_r; // Next valid word is a second word
	logic jmp_r; // Second word belongs to a long jump
	logic [3:0] hi_r; // Low nibble of the last first word
	wire logic [5:0] op = i_instr[9:4];
	wire logic first = i_instr_valid && !o_busy && !sec_r;
	wire logic two = op == `NCD_OP_IMM_NE_MEM_CMP_DIRECT || op == `NCD_OP_LONG_UNCOND_JUMP || op == `NCD_OP_BRL
		|| op == `NCD_OP_CALL || i_instr == `NCD_W_ACC_NE_MEM_CMP_DIRECT || i_instr == `NCD_W_ACC_LE_MEM_CMP_DIRECT
		|| op == `NCD_OP_IMM_LE_MEM_CMP_DIRECT || (i_instr[9:6] == `NCD_HI_BITD && i_instr[5:4] != 2'b11);
	// Second-word marker, held until the second word arrives
	always_ff @(posedge i_core_clk)
	begin
		sec_r <= i_rst_n && ((first && two) || (sec_r && !i_instr_valid));
		jmp_r <= (first && op == `NCD_OP_LONG_UNCOND_JUMP) || (sec_r && jmp_r && !i_instr_valid);
	end
	// Upper target bits
	always_ff @(posedge i_core_clk)
	begin
		if (first)
			hi_r <= i_instr[3:0];
	end
	// ------------------------------
	// Properties
	// ------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	a_imm_ne_status: assert property (first && op == `NCD_OP_IMM_NE_MEM_CMP |=>
		o_status == ($past(i_instr[3:0]) != $past(i_regs.mem))) else $error("imm ne bad");
	a_acc_ne_status: assert property (first && i_instr == `NCD_W_ACC_NE_MEM_CMP |=>
		o_status == ($past(i_regs.acc) != $past(i_regs.mem))) else $error("acc ne bad");
	a_idx_ne_status: assert property (first && op == `NCD_OP_INDEX_NE_IMM_CMP |=>
		o_status == ($past(i_regs.yidx) != $past(i_instr[3:0]))) else $error("idx ne bad");
	a_imm_le_status: assert property (first && op == `NCD_OP_IMM_LE_MEM_CMP |=>
		o_status == ($past(i_instr[3:0]) <= $past(i_regs.mem))) else $error("imm le bad");
	a_latch_set_now: assert property (first && op == `NCD_OP_PIN_LATCH_SET_DIRECT |=>
		o_pin_latch[$past(i_instr[3:0])] && o_status) else $error("latch set bad");
	a_port_write: assert property (first && op == `NCD_OP_LRA |=>
		o_port_regs[4*$past(i_instr[3:0]) +: 4] == $past(i_regs.acc)) else $error("port bad");
	a_call_wait: assert property (first && i_instr[9:6] == 4'h7 && o_status |=>
		o_busy ##1 !o_busy) else $error("call wait bad");
	a_ret_wait: assert property (first && i_instr == `NCD_W_RTN |=>
		o_busy [*2] ##1 !o_busy) else $error("return wait bad");
	a_rti_enable: assert property (first && i_instr == `NCD_W_INTERRUPT_RETURN |->
		##[1:3] o_irq_enable_flag) else $error("irq enable bad");
	a_jump_target: assert property (sec_r && jmp_r && i_instr_valid |=>
		o_pc == PC_W'({$past(hi_r), $past(i_instr)})) else $error("jump bad");
	a_standby_mode: assert property (first && i_instr == `NCD_W_SBY |=>
		o_pmode == ($past(i_subactive) ? NCD_PM_WATCH : NCD_PM_STANDBY)) else $error("mode bad");
	c_return: cover property (first && i_instr == `NCD_W_RTN);
	c_jump: cover property (sec_r && jmp_r);
	c_watch: cover property (first && i_instr == `NCD_W_SBY && i_subactive);
endmodule // ncd_decode_sva
bind ncd_decode ncd_decode_sva #(.PC_W(PC_W), .SP_DEPTH(SP_DEPTH)) u_ncd_decode_sva (
	.i_core_clk, .i_rst_n, .i_instr_valid, .i_instr, .i_regs, .i_subactive, .o_pc, .o_status,
	.o_irq_enable_flag, .o_pin_latch, .o_port_regs, .o_pmode, .o_busy);

/* File: tb/tb.sv */
// Self-checking bench for the control-flow decoder
`include "ncd_map.svh"
module tb
	import ncd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_core_clk = 1'b0;
	logic i_rst_n, i_instr_valid, i_subactive, i_stop_watch;
	logic [9:0] i_instr, d;
	ncd_regs_s i_regs;
	logic [13:0] o_pc;
	logic o_status, o_irq_enable_flag, o_carry_flag, o_mem_we, o_mem_direct, o_acc_we, o_breg_we;
	logic o_busy;
	logic [3:0] o_mem_wdata, o_reg_wdata, imm, v;
	logic [9:0] o_mem_addr;
	logic [15:0] o_pin_latch;
	logic [63:0] o_port_regs;
	ncd_pmode_e o_pmode;
	int n_fail = 0;
	int n_checks = 0;
	int k;
	// Clock at 200 MHz
	always #2.5 i_core_clk = ~i_core_clk;
	ncd_decode u_ncd_decode (.i_core_clk, .i_rst_n, .i_instr_valid, .i_instr, .i_regs,
		.i_subactive, .i_stop_watch, .o_pc, .o_status, .o_irq_enable_flag, .o_carry_flag,
		.o_mem_we, .o_mem_wdata, .o_mem_direct, .o_mem_addr, .o_acc_we, .o_breg_we,
		.o_reg_wdata, .o_pin_latch, .o_port_regs, .o_pmode, .o_busy);
	// ------------------------------
	// Helpers
	// ------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (n_fail == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Present one word for one edge, valid left high
	task automatic issue(input logic [9:0] w);
		i_instr = w;
		i_instr_valid = 1'b1;
		@(negedge i_core_clk);
	endtask
	// Issue a word and count its wait cycles
	task automatic waits(input logic [9:0] w, input int n);
		int c;
		c = 0;
		issue(w);
		i_instr_valid = 1'b0;
		while (o_busy === 1'b1 && c < 10)
		begin
			@(negedge i_core_clk);
			c++;
		end
		@(negedge i_core_clk);
		check(c, n);
	endtask
	function automatic ncd_regs_s rnd();
		return ncd_regs_s'(16'($urandom));
	endfunction
	// Compare word and the status it should leave
	function automatic logic [9:0] word_of(input int k, input logic [3:0] i);
		logic [9:0] t [8];
		t = '{{`NCD_OP_IMM_NE_MEM_CMP, i}, {`NCD_OP_INDEX_NE_IMM_CMP, i}, {`NCD_OP_IMM_LE_MEM_CMP, i}, {`NCD_OP_ACC_LE_IMM_CMP, i},
			`NCD_W_ACC_NE_MEM_CMP, `NCD_W_BREG_NE_MEM_CMP, `NCD_W_ACC_LE_MEM_CMP, `NCD_W_BREG_LE_MEM_CMP};
		return t[k];
	endfunction
	function automatic logic exp_st(input int k, input logic [3:0] i, input ncd_regs_s r);
		logic e [8];
		e = '{i != r.mem, r.yidx != i, i <= r.mem, r.acc <= i, r.acc != r.mem,
			r.breg != r.mem, r.acc <= r.mem, r.breg <= r.mem};
		return e[k];
	endfunction
	// ------------------------------
	// Main sequence
	// ------------------------------
	initial
	begin
		{i_rst_n, i_instr_valid, i_subactive, i_stop_watch, i_instr} = '0;
		i_regs = '0;
		void'($urandom(88));
		repeat (2) @(negedge i_core_clk);
		check({o_status, o_pmode, o_pin_latch, o_pc, o_irq_enable_flag, o_busy}, 35'h400000000);
		check(o_port_regs, 64'h0);
		i_rst_n = 1'b1;
		for (int j = 0; j < 64; j++)
		begin
			k = j % 8;
			imm = 4'($urandom);
			i_regs = (j % 16 < 8) ? rnd() : ncd_regs_s'({4{imm}});
			issue(word_of(k, imm));
			check(o_status, exp_st(k, imm, i_regs));
		end
		for (int j = 0; j < 6; j++)
		begin
			imm = 4'($urandom);
			d = 10'($urandom);
			k = (j % 3 == 0) ? 0 : (j % 3 == 1) ? 4 : 6;
			i_regs = (j < 3) ? rnd() : ncd_regs_s'({4{imm}});
			issue(k == 0 ? {`NCD_OP_IMM_NE_MEM_CMP_DIRECT, imm} : k == 4 ? `NCD_W_ACC_NE_MEM_CMP_DIRECT : `NCD_W_ACC_LE_MEM_CMP_DIRECT);
			issue(d);
			check(o_status, exp_st(k, imm, i_regs));
			check({o_mem_direct, o_mem_addr}, {1'b1, d});
		end
		for (int n = 0; n < 4; n++)
		begin
			i_regs = rnd();
			issue({8'h21, 2'(n)});
			check({o_mem_we, o_mem_wdata}, {1'b1, i_regs.mem | 4'(1 << n)});
			issue({8'h22, 2'(n)});
			check({o_mem_we, o_mem_wdata}, {1'b1, i_regs.mem & ~4'(1 << n)});
			issue({8'h23, 2'(n)});
			check(o_status, i_regs.mem[n]);
		end
		for (int m = 0; m < 16; m++)
		begin
			issue({`NCD_OP_PIN_LATCH_SET_DIRECT, 4'(m)});
			check({o_pin_latch[m], o_status}, 2'b11);
			issue({`NCD_OP_PIN_LATCH_CLEAR_DIRECT, 4'(m)});
			issue({`NCD_OP_TDD, 4'(m)});
			check({o_pin_latch[m], o_status}, 2'b00);
			i_regs.yidx = 4'(15 - m);
			issue(`NCD_W_SED);
			issue(`NCD_W_TD);
			check({o_pin_latch[15 - m], o_status}, 2'b11);
			issue(`NCD_W_RED);
			check(o_pin_latch[15 - m], 1'b0);
			i_regs = rnd();
			v = m[0] ? i_regs.breg : i_regs.acc;
			issue(m[0] ? {`NCD_OP_LRB, 4'(m)} : {`NCD_OP_LRA, 4'(m)});
			check(o_port_regs[4*m +: 4], v);
			i_regs = rnd();
			issue(m[0] ? {`NCD_OP_LBR, 4'(m)} : {`NCD_OP_LAR, 4'(m)});
			check({o_acc_we, o_breg_we, o_reg_wdata}, {~m[0], m[0], v});
		end
		// Jumps, branches on both status values, calls and returns
		imm = 4'($urandom);
		d = {2'($urandom), 8'h10};
		issue({`NCD_OP_LONG_UNCOND_JUMP, imm});
		issue(d);
		check(o_pc, {imm, d});
		i_regs.mem = 4'h5;
		issue({`NCD_OP_IMM_NE_MEM_CMP, 4'h5});
		issue({`NCD_OP_BRL, ~imm});
		issue(d);
		check(o_pc == {~imm, d}, 1'b0);
		issue({`NCD_OP_BRL, ~imm});
		issue(d);
		check(o_pc, {~imm, d});
		issue(10'h35a);
		check(o_pc, {~imm, d[9:8], 8'h5a});
		waits(10'h1ea, 1);
		check(o_pc, 14'h002a);
		waits(`NCD_W_RTN, 2);
		check(o_pc, {~imm, d[9:8], 8'h5b});
		issue({`NCD_OP_CALL, imm});
		issue(d);
		check(o_pc, {imm, d});
		waits(`NCD_W_INTERRUPT_RETURN, 2);
		check(o_irq_enable_flag, 1'b1);
		check(o_pc, {~imm, d[9:8], 8'h5d});
		for (int p = 0; p < 4; p++)
		begin
			i_subactive = p[0];
			i_stop_watch = p[0];
			issue(p[1] ? `NCD_W_STOP : `NCD_W_SBY);
			check(o_pmode, p[0] ? NCD_PM_WATCH : p[1] ? NCD_PM_STOP : NCD_PM_STANDBY);
		end
		tally_and_finish();
	end
	// Watchdog against a hang
	initial
	begin
		#20us;
		n_fail++;
		tally_and_finish();
	end
endmodule // tb
